// ==== vppa_pkg.sv ====
//
// Purpose: Constants for the emulated partner ability register of a
//          virtual PHY port.
// Assumes: One 32-bit memory-map word; 16-bit management view.
// Notes:   Bit positions follow the standard partner ability layout.
//
package vppa_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register geometry
    localparam int unsigned MAP_WIDTH  = 32;   // Memory-map word width
    localparam int unsigned MGMT_WIDTH = 16;   // Management view width

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned NEXT_PAGE_BIT = 15;  // Next page offer
    localparam int unsigned ACK_BIT       = 14;  // Acknowledge
    localparam int unsigned FAULT_BIT     = 13;  // Remote fault
    localparam int unsigned ASYM_BIT      = 11;  // Asymmetric pause
    localparam int unsigned SYM_BIT       = 10;  // Symmetric pause
    localparam int unsigned T4_BIT        = 9;   // 100BASE-T4
    localparam int unsigned TECH_MSB      = 8;   // 100BASE-X full duplex
    localparam int unsigned TECH_LSB      = 5;   // 10BASE-T half duplex
    localparam int unsigned SEL_MSB       = 4;   // Selector field top
    localparam int unsigned SEL_LSB       = 0;   // Selector field bottom

    ////////////////////////////////////////////////////////////////////////
    // Field values
    localparam logic [4:0] SELECTOR_8023 = 5'h01;  // Ethernet message type
    localparam logic [3:0] TECH_10_FD    = 4'h2;   // 0010
    localparam logic [3:0] TECH_100_FD   = 4'h8;   // 1000
    localparam logic [3:0] TECH_10_HD    = 4'h1;   // 0001
    localparam logic [3:0] TECH_100_HD   = 4'h4;   // 0100
    localparam logic [3:0] TECH_NONE     = 4'h0;   // Failed negotiation

    // Pause pairs are {asymmetric, symmetric}
    localparam logic [1:0] PAUSE_NONE = 2'h0;
    localparam logic [1:0] PAUSE_SYM  = 2'h1;
    localparam logic [1:0] PAUSE_ASYM = 2'h2;
    localparam logic [1:0] PAUSE_BOTH = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [3:0] RST_TECH    = 4'h0;
    localparam logic [1:0] RST_PAUSE   = 2'h0;
    localparam logic       RST_AN_ABLE = 1'b1;

endpackage

// ==== vppa_partner_ability.sv ====
//
// Purpose: Emulated link partner ability register of a virtual PHY.
// Assumes: Straps are pins; advertisement and negotiation events come
//          from logic on core_clk_i.
// Notes:   Read-only; contents change only when negotiation completes.
`timescale 1ns/1ps

module vppa_partner_ability
    import vppa_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  duplex_strap_i,
    input  wire logic                  speed_strap_i,
    input  wire logic                  flow_control_pause_strap_i,
    input  wire logic [1:0]            local_pause_adv_i,
    input  wire logic [3:0]            local_tech_adv_i,
    input  wire logic                  an_complete_i,
    input  wire logic                  reg_rd_i,
    input  wire logic                  reg_wr_i,
    input  wire logic [MAP_WIDTH-1:0]  reg_wdata_i,
    output logic      [MAP_WIDTH-1:0]  ability_map_o,
    output logic      [MGMT_WIDTH-1:0] ability_mgmt_o,
    output logic                       partner_an_able_o
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0]            strap_s1;   // First synchroniser stage
        logic [2:0]            strap_s2;   // Second synchroniser stage
        logic [3:0]            tech;       // Partner technology bits
        logic [1:0]            pause;      // Partner {asym, sym}
        logic                  an_able;    // Partner negotiation able
        logic [MAP_WIDTH-1:0]  map_word;   // Memory-map view
        logic [MGMT_WIDTH-1:0] mgmt_word;  // Management view
    } vppa_state_t;

    vppa_state_t st_r;                      // Registered state
    vppa_state_t st_nxt;                    // Next state

    logic        dup_s;                     // Synchronised duplex strap
    logic        spd_s;                     // Synchronised speed strap
    logic        fc_s;                      // Synchronised flow strap
    logic [3:0]  strap_tech;                // Technology from straps
    logic        an_ok;                     // Common bits exist
    logic [1:0]  pause_res;                 // Mapped partner pause

    // Bus writes carry nothing into this register
    logic        unused_wr;
    assign unused_wr = reg_wr_i ^ (^reg_wdata_i) ^ reg_rd_i;

    ////////////////////////////////////////////////////////////////////////
    // Technology ability from duplex and speed straps
    // Exactly one bit is set for every strap pair
    function automatic logic [3:0] tech_of(input logic dup,
                                           input logic spd);
        logic [3:0] t;
        t = TECH_NONE;
        if (dup) begin
            t = spd ? TECH_100_FD : TECH_10_FD;
        end else begin
            t = spd ? TECH_100_HD : TECH_10_HD;
        end
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Partner pause from local advertisement and flow strap
    function automatic logic [1:0] pause_of(input logic [1:0] adv,
                                            input logic       fc);
        logic [1:0] p;
        p = PAUSE_NONE;
        case (adv)
            PAUSE_NONE: begin
                p = PAUSE_NONE;
            end
            PAUSE_SYM: begin
                p = PAUSE_SYM;
            end
            PAUSE_ASYM: begin
                p = PAUSE_BOTH;
            end
            PAUSE_BOTH: begin
                p = fc ? PAUSE_BOTH : PAUSE_ASYM;
            end
            default: begin
                p = PAUSE_NONE;
            end
        endcase
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Assemble the 16-bit ability word
    function automatic logic [MGMT_WIDTH-1:0] word_of(
        input logic [3:0] tech,
        input logic [1:0] pause);
        logic [MGMT_WIDTH-1:0] w;
        w = '0;
        w[NEXT_PAGE_BIT]     = 1'b0;
        w[ACK_BIT]           = 1'b0;
        w[FAULT_BIT]         = 1'b0;
        w[ASYM_BIT]          = pause[1];
        w[SYM_BIT]           = pause[0];
        w[T4_BIT]            = 1'b0;
        w[TECH_MSB:TECH_LSB] = tech;
        w[SEL_MSB:SEL_LSB]   = SELECTOR_8023;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decoded views of the synchronised straps
    always_comb begin
        dup_s      = st_r.strap_s2[2];
        spd_s      = st_r.strap_s2[1];
        fc_s       = st_r.strap_s2[0];
        strap_tech = tech_of(dup_s, spd_s);
        an_ok      = |(strap_tech & local_tech_adv_i);
        pause_res  = pause_of(local_pause_adv_i, fc_s);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt          = st_r;
        // Straps are pins: two stages before use
        // A strap change needs three edges to reach a completion;
        // straps are meant to sit still, so there is no settling filter
        st_nxt.strap_s1 = {duplex_strap_i, speed_strap_i,
                           flow_control_pause_strap_i};
        st_nxt.strap_s2 = st_r.strap_s1;
        // Base page is answered at once on completion
        if (an_complete_i) begin
            st_nxt.pause   = pause_res;
            st_nxt.an_able = an_ok;
            if (an_ok) begin
                st_nxt.tech = strap_tech;
            end else begin
                st_nxt.tech = TECH_NONE;
            end
        end
        // Views are rebuilt from latched fields only
        st_nxt.mgmt_word = word_of(st_nxt.tech, st_nxt.pause);
        st_nxt.map_word  = {{(MAP_WIDTH-MGMT_WIDTH){1'b0}},
                            st_nxt.mgmt_word};
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            // Negotiation-able partner with no abilities yet,
            // as seen before any negotiation has run
            st_r           <= '0;
            st_r.tech      <= RST_TECH;
            st_r.pause     <= RST_PAUSE;
            st_r.an_able   <= RST_AN_ABLE;
            st_r.mgmt_word <= word_of(RST_TECH, RST_PAUSE);
            st_r.map_word  <= {{(MAP_WIDTH-MGMT_WIDTH){1'b0}},
                               word_of(RST_TECH, RST_PAUSE)};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    // Both views are registered from one assembled next word, so the two
    // read paths can never disagree
    assign ability_map_o     = st_r.map_word;
    assign ability_mgmt_o    = st_r.mgmt_word;
    assign partner_an_able_o = st_r.an_able;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    // Completion with common bits
    sequence s_done_ok;
        an_complete_i && an_ok;
    endsequence

    // Completion without common bits
    sequence s_done_fail;
        an_complete_i && !an_ok;
    endsequence

    // No 100BASE-T4 ever
    AST_T4_ZERO: assert property (!ability_map_o[T4_BIT])
        else $error("T4 bit set");

    // Full duplex strap result
    AST_TECH_FULL: assert property (s_done_ok ##0 dup_s |=>
        ability_map_o[TECH_MSB:TECH_LSB] ==
        ($past(spd_s) ? TECH_100_FD : TECH_10_FD))
        else $error("Full duplex ability wrong");

    // Half duplex strap result
    AST_TECH_HALF: assert property (s_done_ok ##0 !dup_s |=>
        ability_map_o[TECH_MSB:TECH_LSB] ==
        ($past(spd_s) ? TECH_100_HD : TECH_10_HD))
        else $error("Half duplex ability wrong");

    // Exactly one technology bit after success
    AST_TECH_ONEHOT: assert property (s_done_ok |=>
        $onehot(ability_map_o[TECH_MSB:TECH_LSB]))
        else $error("Technology bits not one-hot");

    // No 100 Mb technology bits at low speed
    AST_TECH_10: assert property (s_done_ok ##0 !spd_s |=>
        ability_map_o[TECH_MSB:TECH_MSB-1] == 2'h0)
        else $error("100 Mb bit set at 10 Mb");

    // Failure clears technology and negotiation able
    AST_TECH_FAIL: assert property (s_done_fail |=>
        ability_map_o[TECH_MSB:TECH_LSB] == TECH_NONE &&
        !partner_an_able_o)
        else $error("Failed negotiation still reports ability");

    // Selector constant
    AST_SELECTOR: assert property (ability_mgmt_o[SEL_MSB:SEL_LSB] ==
        SELECTOR_8023)
        else $error("Selector not 00001");

    // Upper half padding, low half equals serial view
    AST_WIDTHS: assert property (ability_map_o[MAP_WIDTH-1:MGMT_WIDTH]
        == '0 && ability_map_o[MGMT_WIDTH-1:0] == ability_mgmt_o)
        else $error("Map and serial views disagree");

    // No fault, no next page
    AST_NO_FAULT: assert property (!ability_mgmt_o[FAULT_BIT] &&
        !ability_mgmt_o[NEXT_PAGE_BIT])
        else $error("Fault or next page offered");

    // Single-kind advertisement mapping
    AST_PAUSE_MAP: assert property (an_complete_i &&
        local_pause_adv_i != PAUSE_BOTH |=>
        ability_mgmt_o[ASYM_BIT:SYM_BIT] ==
        ($past(local_pause_adv_i) == PAUSE_ASYM ? PAUSE_BOTH :
         $past(local_pause_adv_i)))
        else $error("Pause mapping wrong");

    // Both kinds advertised: strap decides
    AST_PAUSE_BOTH: assert property (an_complete_i &&
        local_pause_adv_i == PAUSE_BOTH |=>
        ability_mgmt_o[ASYM_BIT:SYM_BIT] ==
        ($past(fc_s) ? PAUSE_BOTH : PAUSE_ASYM))
        else $error("Pause with both advertised wrong");

    // Pause holds between completions
    AST_PAUSE_HOLD: assert property (!an_complete_i |=>
        $stable(ability_mgmt_o[ASYM_BIT:SYM_BIT]))
        else $error("Pause changed without negotiation");

    // Negotiation able follows common bits
    AST_AN_ABLE: assert property (s_done_ok |=> partner_an_able_o)
        else $error("Partner not negotiation able");

    // Reads and writes leave the word untouched
    AST_NO_SIDE: assert property ((reg_rd_i || reg_wr_i) &&
        !an_complete_i |=> $stable(ability_map_o))
        else $error("Access changed the register");

    // A cycle without a completion pulse
    sequence s_quiet;
        !an_complete_i;
    endsequence

    // Whole word holds between completions
    AST_WORD_HOLD: assert property (s_quiet |=>
        $stable(ability_map_o))
        else $error("Ability word changed without negotiation");

    // Negotiation able holds between completions
    AST_ABLE_HOLD: assert property (s_quiet |=>
        $stable(partner_an_able_o))
        else $error("Negotiation able changed without negotiation");

    // Reported ability shares a bit with the local advertisement
    AST_TECH_COMMON: assert property (s_done_ok |=>
        |(ability_map_o[TECH_MSB:TECH_LSB] & $past(local_tech_adv_i)))
        else $error("Reported ability shares no advertised bit");

    // Selector also on the memory-map view
    AST_SEL_MAP: assert property (ability_map_o[SEL_MSB:SEL_LSB] ==
        SELECTOR_8023)
        else $error("Map selector not 00001");

endmodule

// ==== vppa_neg_model.sv ====
//
// Purpose: Far-side model that runs negotiation for the ability register.
// Assumes: One clock; bench requests a completion with go_i.
// Notes:   Advertisement keeps moving after each pulse, as real logic may.
//
`timescale 1ns/1ps

module vppa_neg_model (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       go_i,
    input  wire logic [1:0] pause_i,
    input  wire logic [3:0] tech_i,
    output logic            an_complete_o,
    output logic      [1:0] local_pause_adv_o,
    output logic      [3:0] local_tech_adv_o
);

    ////////////////////////////////////////////////////////////////////////
    // One completion pulse per request, advertisement valid with it
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            an_complete_o     <= 1'b0;
            local_pause_adv_o <= 2'h0;
            local_tech_adv_o  <= 4'h0;
        end else if (go_i && !an_complete_o) begin
            // Present the requested advertisement with the pulse
            an_complete_o     <= 1'b1;
            local_pause_adv_o <= pause_i;
            local_tech_adv_o  <= tech_i;
        end else begin
            // Outside the pulse the advertisement toggles every cycle
            an_complete_o     <= 1'b0;
            local_pause_adv_o <= ~local_pause_adv_o;
            local_tech_adv_o  <= ~local_tech_adv_o;
        end
    end

endmodule

// ==== vppa_partner_ability_tb_top.sv ====
//
// Purpose: Self-checking bench for the emulated partner ability register.
// Assumes: Straps settle within four cycles through the synchronisers.
// Notes:   Reset and ignored-access cases first, then table rows, a held-value write and a mid-run reset.
//
`timescale 1ns/1ps

module vppa_partner_ability_tb_top
    import vppa_pkg::*;
;
    // One table row: straps, advertisement, expected tech, pause, able
    typedef struct packed {
        logic       dup;
        logic       spd;
        logic       fc;
        logic [1:0] advp;
        logic [3:0] advt;
        logic [3:0] tech;
        logic [1:0] pause;
        logic       able;
    } vppa_row_t;

    localparam vppa_row_t ROWS [7] = '{
        '{1'b1, 1'b0, 1'b0, 2'h0, 4'hf, 4'h2, 2'h0, 1'b1},
        '{1'b1, 1'b1, 1'b0, 2'h1, 4'h8, 4'h8, 2'h1, 1'b1},
        '{1'b0, 1'b0, 1'b0, 2'h2, 4'h1, 4'h1, 2'h3, 1'b1},
        '{1'b0, 1'b1, 1'b0, 2'h3, 4'h4, 4'h4, 2'h2, 1'b1},
        '{1'b1, 1'b1, 1'b1, 2'h3, 4'h8, 4'h8, 2'h3, 1'b1},
        '{1'b1, 1'b0, 1'b1, 2'h3, 4'h8, 4'h0, 2'h3, 1'b0},
        '{1'b0, 1'b1, 1'b1, 2'h3, 4'hf, 4'h4, 2'h3, 1'b1}
    };

    logic                  core_clk_i;   // 50 MHz clock
    logic                  reset_i;      // Synchronous reset
    logic                  dup;          // Duplex strap
    logic                  spd;          // Speed strap
    logic                  fc;           // Flow-control strap
    logic                  go;           // Negotiation request
    logic [1:0]            pause_req;    // Requested pause advertisement
    logic [3:0]            tech_req;     // Requested tech advertisement
    logic                  an_complete;  // Completion pulse
    logic [1:0]            adv_pause;    // Local pause advertisement
    logic [3:0]            adv_tech;     // Local tech advertisement
    logic                  rd;           // Read strobe
    logic                  wr;           // Write strobe
    logic [MAP_WIDTH-1:0]  wdata;        // Write data
    logic [MAP_WIDTH-1:0]  map_word;     // Memory-map view
    logic [MGMT_WIDTH-1:0] mgmt_word;    // Management view
    logic                  an_able;      // Partner negotiation able
    int                    error_cnt;    // Mismatches
    int                    checked;      // Comparisons
    vppa_row_t             row;          // Current table row

    ////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    vppa_partner_ability i_vppa_partner_ability (
        .core_clk_i                 (core_clk_i),
        .reset_i                    (reset_i),
        .duplex_strap_i             (dup),
        .speed_strap_i              (spd),
        .flow_control_pause_strap_i (fc),
        .local_pause_adv_i          (adv_pause),
        .local_tech_adv_i           (adv_tech),
        .an_complete_i              (an_complete),
        .reg_rd_i                   (rd),
        .reg_wr_i                   (wr),
        .reg_wdata_i                (wdata),
        .ability_map_o              (map_word),
        .ability_mgmt_o             (mgmt_word),
        .partner_an_able_o          (an_able)
    );

    vppa_neg_model i_vppa_neg_model (
        .core_clk_i        (core_clk_i),
        .reset_i           (reset_i),
        .go_i              (go),
        .pause_i           (pause_req),
        .tech_i            (tech_req),
        .an_complete_o     (an_complete),
        .local_pause_adv_o (adv_pause),
        .local_tech_adv_o  (adv_tech)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    // Whole word: pause, zero T4, tech, selector, zero upper half
    task automatic chk_word(input logic [3:0] t, input logic [1:0] p,
                            input logic a);
        logic [31:0] e;
        e = {16'h0, 4'h0, p, 1'b0, t, 5'h01};
        chk("ability_map", e, map_word);
        chk("ability_mgmt", e, {16'h0, mgmt_word});
        chk("an_able", {31'h0, a}, {31'h0, an_able});
    endtask

    // Request one completion; outputs are settled on return
    task automatic negotiate(input logic [1:0] p, input logic [3:0] t);
        @(posedge core_clk_i);
        go        <= 1'b1;
        pause_req <= p;
        tech_req  <= t;
        @(posedge core_clk_i);
        go        <= 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic conclude();
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung run
    initial begin
        repeat (5000) @(posedge core_clk_i);
        error_cnt++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_i = 1'b1;
        {dup, spd, fc, go, rd, wr} = 6'h0;
        pause_req = 2'h0;
        tech_req  = 4'h0;
        wdata     = 32'h0;
        error_cnt = 0;
        checked   = 0;
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk_word(RST_TECH, RST_PAUSE, RST_AN_ABLE);
        // Reads and writes must leave the word alone
        @(posedge core_clk_i);
        rd    <= 1'b1;
        wr    <= 1'b1;
        wdata <= 32'hffff_ffff;
        repeat (3) @(posedge core_clk_i);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk_word(RST_TECH, RST_PAUSE, RST_AN_ABLE);
        // Table rows: straps, advertisement, completion, latched result
        foreach (ROWS[i]) begin
            row = ROWS[i];
            @(posedge core_clk_i);
            dup <= row.dup;
            spd <= row.spd;
            fc  <= row.fc;
            repeat (4) @(posedge core_clk_i);
            negotiate(row.advp, row.advt);
            chk_word(row.tech, row.pause, row.able);
            repeat (3) @(posedge core_clk_i);
            #1;
            chk_word(row.tech, row.pause, row.able);
        end
        // Write during held value, then a reset in mid-run
        @(posedge core_clk_i);
        wr    <= 1'b1;
        wdata <= 32'h0000_0000;
        @(posedge core_clk_i);
        wr <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk_word(ROWS[6].tech, ROWS[6].pause, ROWS[6].able);
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk_word(RST_TECH, RST_PAUSE, RST_AN_ABLE);
        conclude();
    end

endmodule
